// [src/smpc_ctrl.sv]
// Function
// - Transfer in flight when slow clock ends finishes with slow waveforms.
// - Page reads only when page mode enabled; page size 4,8,16,32 bytes.
// - Pages are naturally aligned to their own size.
// - Page address is upper address bits above the page offset.
// - Page mode holds read strobe and chip select low together, no setup/hold.
// - First page read uses cs read pulse, page hits use read strobe pulse.
// - Page mode ignores read setups and read cycle length.
// - Page timings used as programmed, never checked.
// - Same chip select and page address is a hit, short time.
// - Different page or chip select starts a long first access.
// - Any access in between releases chip select and breaks the page.
// - Each chip select owns four registers at 0x10 times its number.
// - A mode register write marks the configuration complete.
// - Timing and mode writes blocked while write protection is set.
// - Setup length is top bit times 128 plus low five bits.
// - Pulse length is top bit times 256 plus low six bits.
// - Cycle length is upper two bits times 256 plus low seven.
// - Slow clock indication swaps in fixed waveforms on all chip selects.
//
// Chosen here: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module smpc_ctrl (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic cfg_done,
	input wire logic slow_clock_in,
	input wire logic acc_req,
	input wire logic acc_write,
	input wire logic [1:0] acc_cs,
	input wire logic [23:0] acc_addr,
	output logic acc_ready,
	output logic acc_done,
	output logic [23:0] mem_addr,
	output logic [3:0] chip_select_n,
	output logic read_strobe_n,
	output logic write_strobe_n
);
	typedef struct packed {
		logic [3:0][31:0] setup;
		logic [3:0][31:0] pulse;
		logic [3:0][31:0] cycle;
		logic [3:0][31:0] mode;
		logic [31:0] ocms;
		logic write_protect_enable;
		logic [31:0] rdata;
		logic cfg_done;
		logic slow_s1;
		logic slow_s2;
		smpc_pkg::smpc_state_e st;
		logic [9:0] cnt;
		logic [9:0] csp;
		logic [9:0] sgs;
		logic [9:0] sgp;
		logic [9:0] tot;
		logic wr;
		logic page;
		logic [1:0] cs;
		logic [23:0] addr;
		logic rec_vld;
		logic [1:0] rec_cs;
		logic [23:0] rec_page;
		logic done;
	} smpc_s;

	smpc_s r_reg, r_next;

	function automatic logic [9:0] setup_len(input logic [5:0] f);
		setup_len = (f[5] ? smpc_pkg::SETUP_HI_W : 10'h000) + {5'h00, f[4:0]};
	endfunction

	function automatic logic [9:0] pulse_len(input logic [6:0] f);
		pulse_len = (f[6] ? smpc_pkg::PULSE_HI_W : 10'h000) + {4'h0, f[5:0]};
	endfunction

	function automatic logic [9:0] cycle_len(input logic [8:0] f);
		cycle_len = {f[8:7], 8'h00} + {3'h0, f[6:0]};
	endfunction

	// Page base keeps only address bits above the offset inside the page
	function automatic logic [23:0] page_of(input logic [23:0] a,
		input logic [1:0] ps);
		page_of = a & ~((24'h000004 << ps) - 24'h000001);
	endfunction

	always_comb begin
		logic [7:0] off;
		logic [1:0] idx;
		logic grp;
		logic hit;
		logic pm;
		logic [31:0] su, pu, cy;
		logic [9:0] csr_s, csr_p, sg_s, sg_p, tl;
		off = reg_addr & 8'h0F;
		idx = reg_addr[5:4];
		grp = reg_addr < (smpc_pkg::CS_STRIDE * 8'(smpc_pkg::NUM_CS));
		hit = 1'b0;
		pm = 1'b0;
		su = 32'h00000000;
		pu = 32'h00000000;
		cy = 32'h00000000;
		csr_s = 10'h000;
		csr_p = 10'h000;
		sg_s = 10'h000;
		sg_p = 10'h000;
		tl = 10'h000;
		r_next = r_reg;
		r_next.cfg_done = 1'b0;
		r_next.done = 1'b0;
		r_next.slow_s1 = slow_clock_in;
		r_next.slow_s2 = r_reg.slow_s1;
		r_next.rdata = 32'h00000000;
		if (reg_wr) begin
			if (grp && !r_reg.write_protect_enable) begin
				if (off == smpc_pkg::OFF_SETUP) begin
					r_next.setup[idx] = reg_wdata & 32'h3F3F3F3F;
				end else if (off == smpc_pkg::OFF_PULSE) begin
					r_next.pulse[idx] = reg_wdata & 32'h7F7F7F7F;
				end else if (off == smpc_pkg::OFF_CYCLE) begin
					r_next.cycle[idx] = reg_wdata & 32'h01FF01FF;
				end else begin
					r_next.mode[idx] = reg_wdata & 32'h311F1133;
					r_next.cfg_done = 1'b1;
				end
			end else if (reg_addr == smpc_pkg::OFF_OCMS) begin
				r_next.ocms = reg_wdata & 32'h00000001;
			end else if (reg_addr == smpc_pkg::OFF_WPMR) begin
				r_next.write_protect_enable = reg_wdata[smpc_pkg::WPMR_EN_BIT];
			end
		end
		if (reg_rd) begin
			if (grp) begin
				if (off == smpc_pkg::OFF_SETUP) begin
					r_next.rdata = r_reg.setup[idx];
				end else if (off == smpc_pkg::OFF_PULSE) begin
					r_next.rdata = r_reg.pulse[idx];
				end else if (off == smpc_pkg::OFF_CYCLE) begin
					r_next.rdata = r_reg.cycle[idx];
				end else begin
					r_next.rdata = r_reg.mode[idx];
				end
			end else if (reg_addr == smpc_pkg::OFF_OCMS) begin
				r_next.rdata = r_reg.ocms;
			end else if (reg_addr == smpc_pkg::OFF_WPMR) begin
				r_next.rdata = {31'h00000000, r_reg.write_protect_enable};
			end
		end
		case (r_reg.st)
			smpc_pkg::SMPC_IDLE: begin
				if (acc_req) begin
					su = r_reg.setup[acc_cs];
					pu = r_reg.pulse[acc_cs];
					cy = r_reg.cycle[acc_cs];
					pm = r_reg.mode[acc_cs][smpc_pkg::MODE_PAGE_MODE_ENABLE_BIT] && !acc_write
						&& !r_reg.slow_s2;
					hit = r_reg.rec_vld && r_reg.rec_cs == acc_cs
						&& r_reg.rec_page == page_of(acc_addr,
						r_reg.mode[acc_cs][smpc_pkg::MODE_PS_LSB +: 2]);
					// Waveform chosen once here and frozen for the whole transfer
					if (r_reg.slow_s2) begin
						sg_s = acc_write ? smpc_pkg::SLOW_WR_SETUP : smpc_pkg::SLOW_RD_SETUP;
						sg_p = acc_write ? smpc_pkg::SLOW_WR_PULSE : smpc_pkg::SLOW_RD_PULSE;
						tl = acc_write ? smpc_pkg::SLOW_WR_CYCLE : smpc_pkg::SLOW_RD_CYCLE;
						csr_p = tl;
					end else if (pm) begin
						sg_s = 10'h000;
						sg_p = hit ? pulse_len(pu[smpc_pkg::PULSE_NRD_LSB +: 7])
							: pulse_len(pu[smpc_pkg::PULSE_CSRD_LSB +: 7]);
						csr_p = sg_p;
						tl = sg_p;
					end else if (acc_write) begin
						sg_s = setup_len(su[smpc_pkg::SETUP_NWE_LSB +: 6]);
						sg_p = pulse_len(pu[smpc_pkg::PULSE_NWE_LSB +: 7]);
						csr_s = setup_len(su[smpc_pkg::SETUP_CSWR_LSB +: 6]);
						csr_p = pulse_len(pu[smpc_pkg::PULSE_CSWR_LSB +: 7]);
						tl = cycle_len(cy[smpc_pkg::CYCLE_NWE_LSB +: 9]);
					end else begin
						sg_s = setup_len(su[smpc_pkg::SETUP_NRD_LSB +: 6]);
						sg_p = pulse_len(pu[smpc_pkg::PULSE_NRD_LSB +: 7]);
						csr_s = setup_len(su[smpc_pkg::SETUP_CSRD_LSB +: 6]);
						csr_p = pulse_len(pu[smpc_pkg::PULSE_CSRD_LSB +: 7]);
						tl = cycle_len(cy[smpc_pkg::CYCLE_NRD_LSB +: 9]);
					end
					r_next.st = smpc_pkg::SMPC_SETUP;
					r_next.cnt = 10'h000;
					r_next.csp = csr_s;
					r_next.sgs = sg_s;
					r_next.sgp = sg_p;
					r_next.tot = (tl > csr_s + csr_p) ? tl : csr_s + csr_p;
					if (sg_s + sg_p > r_next.tot) begin
						r_next.tot = sg_s + sg_p;
					end
					// Cycle of zero still takes one clock
					if (r_next.tot == 10'h000) begin
						r_next.tot = 10'h001;
					end
					r_next.wr = acc_write;
					r_next.page = pm;
					r_next.cs = acc_cs;
					r_next.addr = acc_addr;
					// Record only page reads; anything else forces a break
					r_next.rec_vld = pm;
					r_next.rec_cs = acc_cs;
					r_next.rec_page = page_of(acc_addr,
						r_reg.mode[acc_cs][smpc_pkg::MODE_PS_LSB +: 2]);
				end
			end
			smpc_pkg::SMPC_SETUP, smpc_pkg::SMPC_PULSE, smpc_pkg::SMPC_HOLD: begin
				r_next.cnt = r_reg.cnt + 10'h001;
				if (r_next.cnt >= r_reg.sgs) begin
					r_next.st = smpc_pkg::SMPC_PULSE;
				end
				if (r_next.cnt >= r_reg.sgs + r_reg.sgp) begin
					r_next.st = smpc_pkg::SMPC_HOLD;
				end
				if (r_next.cnt >= r_reg.tot) begin
					r_next.st = smpc_pkg::SMPC_IDLE;
					r_next.done = 1'b1;
				end
			end
			default: r_next.st = smpc_pkg::SMPC_IDLE;
		endcase
		if (!nrst) begin
			for (int i = 0; i < smpc_pkg::NUM_CS; i++) begin
				r_next.setup[i] = smpc_pkg::RST_SETUP;
				r_next.pulse[i] = smpc_pkg::RST_PULSE;
				r_next.cycle[i] = smpc_pkg::RST_CYCLE;
				r_next.mode[i] = smpc_pkg::RST_MODE;
			end
			r_next.ocms = 32'h00000000;
			r_next.write_protect_enable = 1'b0;
			r_next.rdata = 32'h00000000;
			r_next.cfg_done = 1'b0;
			r_next.slow_s1 = 1'b0;
			r_next.slow_s2 = 1'b0;
			r_next.st = smpc_pkg::SMPC_IDLE;
			r_next.cnt = 10'h000;
			r_next.csp = 10'h000;
			r_next.sgs = 10'h000;
			r_next.sgp = 10'h000;
			r_next.tot = 10'h001;
			r_next.wr = 1'b0;
			r_next.page = 1'b0;
			r_next.cs = 2'h0;
			r_next.addr = 24'h000000;
			r_next.rec_vld = 1'b0;
			r_next.rec_cs = 2'h0;
			r_next.rec_page = 24'h000000;
			r_next.done = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		r_reg <= r_next;
	end

	logic busy;
	logic strobe_on;
	logic cs_on;
	assign busy = r_reg.st != smpc_pkg::SMPC_IDLE;
	// Counter at cnt is the cycle currently on the pins
	assign strobe_on = busy && r_reg.cnt >= r_reg.sgs
		&& r_reg.cnt < r_reg.sgs + r_reg.sgp;
	assign cs_on = busy && (r_reg.page || (r_reg.cnt >= r_reg.csp));
	assign reg_rdata = r_reg.rdata;
	assign cfg_done = r_reg.cfg_done;
	assign acc_ready = !busy;
	assign acc_done = r_reg.done;
	assign mem_addr = r_reg.addr;
	assign read_strobe_n = !(strobe_on && !r_reg.wr);
	assign write_strobe_n = !(strobe_on && r_reg.wr);
	generate
		for (genvar g = 0; g < smpc_pkg::NUM_CS; g++) begin : g_cs
			assign chip_select_n[g] = !(cs_on && r_reg.cs == 2'(g));
		end
	endgenerate

	property p_page_same;
		@(posedge clk) disable iff (!nrst)
		(busy && r_reg.page) |-> (read_strobe_n == chip_select_n[r_reg.cs]);
	endproperty
	a_page_same: assert property (p_page_same) else $error("page strobes differ");

	property p_wp_block;
		@(posedge clk) disable iff (!nrst)
		(reg_wr && r_reg.write_protect_enable && reg_addr == smpc_pkg::OFF_SETUP)
			|=> $stable(r_reg.setup[0]);
	endproperty
	a_wp_block: assert property (p_wp_block) else $error("protected write");

	property p_cfg_done;
		@(posedge clk) disable iff (!nrst)
		(reg_wr && !r_reg.write_protect_enable && reg_addr == smpc_pkg::OFF_MODE) |=> cfg_done;
	endproperty
	a_cfg_done: assert property (p_cfg_done) else $error("no config done");

	property p_break_clear;
		@(posedge clk) disable iff (!nrst)
		(!busy && acc_req && (acc_write || r_reg.slow_s2)) |=> !r_reg.rec_vld;
	endproperty
	a_break_clear: assert property (p_break_clear) else $error("record kept");

	property p_slow_len;
		@(posedge clk) disable iff (!nrst)
		(!busy && acc_req && r_reg.slow_s2 && !acc_write)
			|=> (r_reg.tot == smpc_pkg::SLOW_RD_CYCLE);
	endproperty
	a_slow_len: assert property (p_slow_len) else $error("slow length");

	property p_no_page;
		@(posedge clk) disable iff (!nrst)
		(!busy && acc_req && (acc_write
			|| !r_reg.mode[acc_cs][smpc_pkg::MODE_PAGE_MODE_ENABLE_BIT])) |=> !r_reg.page;
	endproperty
	a_no_page: assert property (p_no_page) else $error("stray page");

	// Page reads ignore programmed setups and cycle length
	property p_page_fixed;
		@(posedge clk) disable iff (!nrst)
		(busy && r_reg.page) |-> (r_reg.sgs == 10'h000 && r_reg.csp == 10'h000
			&& r_reg.tot == r_reg.sgp);
	endproperty
	a_page_fixed: assert property (p_page_fixed) else $error("page timing");

	// Waveform must not follow the slow flag once a transfer has started
	property p_frozen;
		@(posedge clk) disable iff (!nrst)
		(busy && $past(busy)) |-> ($stable(r_reg.tot) && $stable(r_reg.sgp)
			&& $stable(r_reg.sgs));
	endproperty
	a_frozen: assert property (p_frozen) else $error("waveform changed");
endmodule // smpc_ctrl
`default_nettype wire

// [src/smpc_pkg.sv]
package smpc_pkg;
	localparam int NUM_CS = 4;
	localparam int ADDR_W = 24;
	localparam logic [7:0] OFF_SETUP = 8'h00;
	localparam logic [7:0] OFF_PULSE = 8'h04;
	localparam logic [7:0] OFF_CYCLE = 8'h08;
	localparam logic [7:0] OFF_MODE = 8'h0C;
	localparam logic [7:0] OFF_OCMS = 8'h80;
	localparam logic [7:0] OFF_KEY1 = 8'h84;
	localparam logic [7:0] OFF_KEY2 = 8'h88;
	localparam logic [7:0] OFF_WPMR = 8'hE4;
	localparam logic [7:0] OFF_WPSR = 8'hE8;
	localparam logic [7:0] CS_STRIDE = 8'h10;
	localparam logic [31:0] RST_SETUP = 32'h01010101;
	localparam logic [31:0] RST_PULSE = 32'h01010101;
	localparam logic [31:0] RST_CYCLE = 32'h00030003;
	localparam logic [31:0] RST_MODE = 32'h10000003;
	localparam int SETUP_NWE_LSB = 0;
	localparam int SETUP_CSWR_LSB = 8;
	localparam int SETUP_NRD_LSB = 16;
	localparam int SETUP_CSRD_LSB = 24;
	localparam int PULSE_NWE_LSB = 0;
	localparam int PULSE_CSWR_LSB = 8;
	localparam int PULSE_NRD_LSB = 16;
	localparam int PULSE_CSRD_LSB = 24;
	localparam int CYCLE_NWE_LSB = 0;
	localparam int CYCLE_NRD_LSB = 16;
	localparam int MODE_PAGE_MODE_ENABLE_BIT = 24;
	localparam int MODE_PS_LSB = 28;
	localparam int WPMR_EN_BIT = 0;
	localparam logic [9:0] SETUP_HI_W = 10'h080;
	localparam logic [9:0] PULSE_HI_W = 10'h100;
	localparam logic [9:0] CYCLE_HI_W = 10'h100;
	localparam logic [9:0] SLOW_RD_SETUP = 10'h001;
	localparam logic [9:0] SLOW_RD_PULSE = 10'h001;
	localparam logic [9:0] SLOW_RD_CYCLE = 10'h002;
	localparam logic [9:0] SLOW_WR_SETUP = 10'h001;
	localparam logic [9:0] SLOW_WR_PULSE = 10'h001;
	localparam logic [9:0] SLOW_WR_CYCLE = 10'h003;
	typedef enum logic [1:0] {
		SMPC_IDLE = 2'b00,
		SMPC_SETUP = 2'b01,
		SMPC_PULSE = 2'b11,
		SMPC_HOLD = 2'b10
	} smpc_state_e;
endpackage

// [testbench/smpc_ctrl_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module smpc_ctrl_bench;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h00000000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic slow_clock_in = 1'b0;
	logic acc_req = 1'b0;
	logic acc_write = 1'b0;
	logic [1:0] acc_cs = 2'h0;
	logic [23:0] acc_addr = 24'h000000;
	logic [31:0] reg_rdata;
	logic cfg_done, acc_ready, acc_done, read_strobe_n, write_strobe_n;
	logic [23:0] mem_addr;
	logic [3:0] chip_select_n;
	logic [7:0] b;
	int rd_len, rd_lead, wr_len, dur, tpa, tsa, sz;
	int bad_count = 0;
	int total_checks = 0;
	int cyc = 0;

	smpc_ctrl i_smpc_ctrl (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .cfg_done, .slow_clock_in, .acc_req,
		.acc_write, .acc_cs, .acc_addr, .acc_ready, .acc_done, .mem_addr,
		.chip_select_n, .read_strobe_n, .write_strobe_n);
	smpc_mem_model i_smpc_mem_model (.clk, .chip_select_n, .read_strobe_n,
		.write_strobe_n, .rd_len, .rd_lead, .wr_len);

	always #2.5 clk = ~clk;

	task automatic final_report;
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t value %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_len(input int got, input int exp);
		total_checks++;
		if (got != exp) begin
			bad_count++;
			$display("ERROR t=%0t length %0d expected %0d", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, e);
	endtask

	task automatic acc(input logic w, input logic [1:0] c,
		input logic [23:0] a);
		int n;
		@(posedge clk);
		acc_req <= 1'b1;
		acc_write <= w;
		acc_cs <= c;
		acc_addr <= a;
		@(negedge clk);
		while (acc_ready !== 1'b1)
			@(negedge clk);
		@(posedge clk);
		acc_req <= 1'b0;
		n = 0;
		while (acc_done !== 1'b1 && n < 2000) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n == 2000)
			chk_len(n, 0);
		dur = n;
		repeat (2) @(posedge clk);
		chk({8'h00, mem_addr}, {8'h00, a});
	endtask

	// Cut a hang short well above the expected run length
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			bad_count++;
			final_report();
		end
	end

	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		for (int c = 0; c < 4; c++) begin
			b = 8'(c) * smpc_pkg::CS_STRIDE;
			rd(b + smpc_pkg::OFF_SETUP, smpc_pkg::RST_SETUP);
			rd(b + smpc_pkg::OFF_PULSE, smpc_pkg::RST_PULSE);
			rd(b + smpc_pkg::OFF_CYCLE, smpc_pkg::RST_CYCLE);
			rd(b + smpc_pkg::OFF_MODE, smpc_pkg::RST_MODE);
		end
		rd(8'hF0, 32'h00000000);
		wr(smpc_pkg::OFF_WPMR, 32'h00000001);
		wr(smpc_pkg::OFF_PULSE, 32'h7F7F7F7F);
		wr(smpc_pkg::OFF_SETUP, 32'h3F3F3F3F);
		rd(smpc_pkg::OFF_PULSE, smpc_pkg::RST_PULSE);
		rd(smpc_pkg::OFF_SETUP, smpc_pkg::RST_SETUP);
		wr(smpc_pkg::OFF_WPMR, 32'h00000000);
		// Plain read on select 0: setup field uses its top bit
		wr(smpc_pkg::OFF_SETUP, 32'h00210000);
		wr(smpc_pkg::OFF_PULSE, 32'h7F050101);
		wr(smpc_pkg::OFF_MODE, 32'h00000003);
		#1;
		chk({31'h0, cfg_done}, 32'h00000001);
		acc(1'b0, 2'h0, 24'h000010);
		chk_len(rd_lead, 129);
		chk_len(rd_len, 5);
		// Select 1 page mode with read setups and cycle set large
		wr(8'h10, 32'h3F3F0101);
		wr(8'h18, 32'h01FF0003);
		for (int k = 0; k < 2; k++) begin
			wr(8'h14, k ? 32'h41020101 : 32'h01050101);
			tpa = k ? 257 : 1;
			tsa = k ? 2 : 5;
			for (int p = 0; p < 4; p++) begin
				sz = 4 << p;
				wr(8'h1C, 32'h01000003 | (32'(p) << 28));
				acc(1'b1, 2'h1, 24'h000040);
				chk_len(wr_len, 1);
				acc(1'b0, 2'h1, 24'h000041);
				chk_len(rd_len, tpa);
				chk_len(dur, tpa);
				chk_len(rd_lead, 0);
				acc(1'b0, 2'h1, 24'(64 + sz - 1));
				chk_len(rd_len, tsa);
				acc(1'b0, 2'h1, 24'(64 + sz));
				chk_len(rd_len, tpa);
			end
		end
		acc(1'b0, 2'h2, 24'h000060);
		acc(1'b0, 2'h1, 24'h000060);
		chk_len(rd_len, 257);
		// Select 3 read stretched by its cycle field alone
		wr(8'h38, 32'h00810003);
		acc(1'b0, 2'h3, 24'h000070);
		chk_len(dur, 257);
		chk_len(rd_len, 1);
		@(posedge clk);
		slow_clock_in <= 1'b1;
		repeat (4) @(posedge clk);
		acc(1'b0, 2'h1, 24'h000061);
		chk_len(rd_len, 1);
		chk_len(rd_lead, 1);
		@(posedge clk);
		slow_clock_in <= 1'b0;
		acc(1'b0, 2'h1, 24'h000062);
		chk_len(rd_len, 1);
		acc(1'b0, 2'h1, 24'h000063);
		chk_len(rd_len, 257);
		final_report();
	end
endmodule // smpc_ctrl_bench
`default_nettype wire

// [testbench/smpc_mem_model.sv]
`timescale 1ns/100ps
`default_nettype none
module smpc_mem_model (
	input wire logic clk,
	input wire logic [3:0] chip_select_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	output int rd_len,
	output int rd_lead,
	output int wr_len
);
	int run = 0;
	int wrun = 0;
	int lead = 0;
	// Never stretches a transfer: this memory has no wait line
	always @(posedge clk) begin
		if (!read_strobe_n)
			run <= run + 1;
		else if (run != 0) begin
			rd_len <= run;
			run <= 0;
		end
		// Lead counts select-low cycles before the strobe falls
		if (&chip_select_n || !read_strobe_n)
			lead <= 0;
		else
			lead <= lead + 1;
		if (!read_strobe_n && run == 0)
			rd_lead <= lead;
		if (!write_strobe_n)
			wrun <= wrun + 1;
		else if (wrun != 0) begin
			wr_len <= wrun;
			wrun <= 0;
		end
	end
endmodule // smpc_mem_model
`default_nettype wire
